// ==== av_switch_control_port_tb_top.sv ====
// av_switch_control_port_tb_top: self-checking bench of the control port.
// assumes: avsc_pkg, avsc_port, avsc_host and the checker compiled first.
`timescale 1ns/1ns
`default_nettype none

module av_switch_control_port_tb_top;
   localparam logic [55:0] CTRL_RESET = 56'h01000000004002;
   // writable bits only, fixed-zero bits kept zero
   localparam logic [7:0] WMASK [8] = '{8'h13, 8'h77, 8'h77, 8'h77, 8'h70, 8'hF7, 8'hF7,
      8'h1F};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic pd_n = 1'b1;
   logic lsb = 1'b0;
   logic adl = 1'b0;
   logic adr = 1'b0;
   logic vs = 1'b0;
   logic [31:0] lfsr = 32'h009A3368;
   logic [7:0] d [8];
   logic [7:0] a8;
   logic [7:0] b8;
   logic [7:0] exp_q [$];
   int err_count = 0;
   int n_compared = 0;
   int n_rst = 0;
   logic mode, sel_n, sclk, sdi, sda_pull, sdo, sdo_oe, sda_oe, int_oe, a_rst, v_rst;
   logic [4:0] gen_oe;
   avsc_pkg::avsc_ctrl_s ctrl;
   wire logic sda_line;
   wire logic ser_in;

   assign sda_line = !(sda_pull || sda_oe);
   assign ser_in = mode ? sdi : sda_line;
   always #50 clk = ~clk;
   always @(posedge clk) if (!reset) n_rst <= n_rst + a_rst + v_rst;

   avsc_port dut (.CLK(clk), .RESET(reset), .POWERDOWN_N(pd_n), .PORT_MODE_SELECT(mode),
      .PORT_SELECT_N(sel_n), .PORT_SERIAL_CLOCK(sclk), .PORT_SERIAL_IN(ser_in),
      .PORT_SERIAL_IN_OUT(), .PORT_SERIAL_IN_OE(sda_oe), .PORT_SERIAL_OUT(sdo),
      .PORT_SERIAL_OUT_OE(sdo_oe), .BUS_ADDR_LSB_PIN(lsb), .AUDIO_LEFT_DETECTED(adl),
      .AUDIO_RIGHT_DETECTED(adr), .VIDEO_SYNC_DETECTED(vs), .AUDIO_DETECT_RESTART(a_rst),
      .VIDEO_DETECT_RESTART(v_rst), .CTRL(ctrl), .INT_OUT(), .INT_OE(int_oe),
      .GENERAL_OUT_BITS(), .GENERAL_OUT_BITS_OE(gen_oe));
   avsc_host host (.clk(clk), .mode(mode), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
      .sda_pull(sda_pull), .sda(sda_line), .sdo(sdo), .sdo_oe(sdo_oe));

   // --------------------------------------------
   // helpers
   // --------------------------------------------
   function automatic logic [7:0] rnd(input logic [7:0] m);
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0] & m;
   endfunction : rnd

   task automatic check(input logic [63:0] seen, input logic [63:0] expv, input string what);
      n_compared++;
      if (seen !== expv) begin
         err_count++;
         $display("wrong value %s expected %0h seen %0h", what, expv, seen);
      end
   endtask : check

   task automatic tend(input string name);
      $display("test %s done", name);
   endtask : tend

   task automatic stop_test();
      if (exp_q.size() != 0) err_count++;
      $display("compared %0d, wrong %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test

   task automatic r4(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.frame4(2'h0, 1'b1, a, 8'h00);
   endtask : r4

   task automatic ib(input logic [7:0] v, input logic rd, input logic mack, input logic [7:0] e);
      exp_q.push_back(e);
      host.xfer(v, rd, mack);
   endtask : ib

   // oldest note against each result the host brings back
   always @(host.got) check(host.res, exp_q.pop_front(), "result");

   // --------------------------------------------
   // scenarios
   // --------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (5) @(posedge clk);
      check(ctrl, CTRL_RESET, "ctrl");
      check(gen_oe, 5'h00, "gen_oe");
      check(int_oe, 1'b0, "int_oe");
      tend("reset values");
      for (int a = 0; a < 8; a++) begin
         d[a] = rnd(WMASK[a]);
         host.frame4(2'h0, 1'b0, a[4:0], d[a]);
      end
      host.frame4(2'h1, 1'b0, 5'h01, ~d[1] & WMASK[1]);
      host.frame4(2'h0, 1'b0, 5'h08, 8'h70);
      check(ctrl, {d[0], d[1], d[2], d[3], d[4], d[5], d[6]}, "ctrl");
      check(gen_oe, 5'(~d[7][4:0]), "gen_oe");
      check(n_rst, 2, "restarts");
      for (int a = 0; a < 8; a++) r4(a[4:0], d[a]);
      r4(5'h08, 8'h00);
      tend("4-wire access");
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         {vs, adr, adl} <= 3'(rnd(8'h07));
         host.frame4(2'h0, 1'b0, 5'h06, {1'b1, 3'(i), 4'h2});
         repeat (6) @(posedge clk);
         check(int_oe, |({vs, adr, adl} & ~3'(i)), "int_oe");
      end
      host.frame4(2'h0, 1'b0, 5'h06, 8'h02);
      {vs, adr, adl} <= 3'b100;
      repeat (4) @(posedge clk);
      vs <= 1'b0;
      repeat (6) @(posedge clk);
      check(int_oe, 1'b1, "int_oe");
      r4(5'h08, 8'h40);
      r4(5'h08, 8'h00);
      check(int_oe, 1'b0, "int_oe");
      tend("interrupt");
      lsb <= 1'b1;
      host.mode <= 1'b0;
      repeat (5) @(posedge clk);
      a8 = rnd(WMASK[7]);
      b8 = rnd(WMASK[0]);
      host.i2c_start();
      ib(8'h20, 1'b0, 1'b1, 8'h01);
      host.i2c_stop();
      host.i2c_start();
      ib(8'h22, 1'b0, 1'b1, 8'h00);
      ib(8'h07, 1'b0, 1'b1, 8'h00);
      ib(a8, 1'b0, 1'b1, 8'h00);
      ib(8'h70, 1'b0, 1'b1, 8'h00);
      ib(b8, 1'b0, 1'b1, 8'h00);
      host.i2c_stop();
      check(gen_oe, 5'(~a8[4:0]), "gen_oe");
      adl <= 1'b1;
      host.i2c_start();
      ib(8'h22, 1'b0, 1'b1, 8'h00);
      ib(8'h07, 1'b0, 1'b1, 8'h00);
      host.i2c_start();
      ib(8'h23, 1'b0, 1'b1, 8'h00);
      ib(8'hFF, 1'b1, 1'b0, a8);
      ib(8'hFF, 1'b1, 1'b0, 8'h10);
      ib(8'hFF, 1'b1, 1'b1, 8'h00);
      host.i2c_stop();
      host.i2c_start();
      ib(8'h23, 1'b0, 1'b1, 8'h00);
      ib(8'hFF, 1'b1, 1'b1, b8);
      host.i2c_stop();
      check(sda_oe, 1'b0, "sda_oe");
      tend("i2c access");
      pd_n <= 1'b0;
      repeat (5) @(posedge clk);
      pd_n <= 1'b1;
      repeat (5) @(posedge clk);
      check(ctrl, CTRL_RESET, "ctrl");
      check(gen_oe, 5'h00, "gen_oe");
      host.i2c_start();
      ib(8'h23, 1'b0, 1'b1, 8'h00);
      ib(8'hFF, 1'b1, 1'b1, 8'h01);
      host.i2c_stop();
      tend("power down");
      stop_test();
   end

   // run takes about 0.5 ms; cut off at six times that
   initial begin
      #3_000_000;
      err_count++;
      stop_test();
   end

endmodule : av_switch_control_port_tb_top

bind avsc_port avsc_port_properties chk (.CLK(CLK), .RESET(RESET),
   .POWERDOWN_N(POWERDOWN_N), .PORT_MODE_SELECT(PORT_MODE_SELECT),
   .PORT_SELECT_N(PORT_SELECT_N), .PORT_SERIAL_CLOCK(PORT_SERIAL_CLOCK),
   .PORT_SERIAL_IN_OUT(PORT_SERIAL_IN_OUT), .PORT_SERIAL_IN_OE(PORT_SERIAL_IN_OE),
   .PORT_SERIAL_OUT_OE(PORT_SERIAL_OUT_OE), .AUDIO_LEFT_DETECTED(AUDIO_LEFT_DETECTED),
   .CTRL(CTRL), .INT_OUT(INT_OUT), .INT_OE(INT_OE), .GENERAL_OUT_BITS(GENERAL_OUT_BITS),
   .GENERAL_OUT_BITS_OE(GENERAL_OUT_BITS_OE));

`default_nettype wire

// ==== avsc_host.sv ====
// avsc_host: host controller model, master of both serial port modes.
// assumes: clk is the system clock; data line resolved outside with pull-up.
`timescale 1ns/1ns
`default_nettype none

module avsc_host (
   // timing reference
   input wire logic clk,
   // pins toward the port
   output logic mode,
   output logic sel_n,
   output logic sclk,
   output logic sdi,
   output logic sda_pull,
   input wire logic sda,
   input wire logic sdo,
   input wire logic sdo_oe
);
   localparam int QTR = 7; // bit time 2.8 us
   logic [7:0] res;
   event got;

   initial begin
      mode = 1'b1;
      sel_n = 1'b1;
      sclk = 1'b1;
      sdi = 1'b0;
      sda_pull = 1'b0;
   end

   // --------------------------------------------
   // 4-wire frames, clock stands high between
   // --------------------------------------------
   task automatic frame4(input logic [1:0] chip, input logic rw, input logic [4:0] addr,
         input logic [7:0] wdata);
      logic [15:0] bits;
      bits = {chip, rw, addr, wdata};
      @(posedge clk);
      #7 sel_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         #16 sclk = 1'b0;
         sdi = bits[15-i];
         #16 sclk = 1'b1;
         // unknown when not driven, so a released output never matches
         if (i >= 8) res[15-i] = sdo_oe ? sdo : 1'bx;
      end
      repeat (8) @(posedge clk);
      sel_n <= 1'b1;
      sdi <= ~sdi;
      repeat (5) @(posedge clk);
      if (rw) -> got;
   endtask : frame4

   // --------------------------------------------
   // i2c master
   // --------------------------------------------
   task automatic qwait();
      repeat (QTR) @(posedge clk);
   endtask : qwait

   // also serves as repeated start
   task automatic i2c_start();
      sda_pull <= 1'b0;
      qwait();
      sclk <= 1'b1;
      qwait();
      sda_pull <= 1'b1;
      qwait();
      sclk <= 1'b0;
      qwait();
   endtask : i2c_start

   task automatic i2c_stop();
      sda_pull <= 1'b1;
      qwait();
      sclk <= 1'b1;
      qwait();
      sda_pull <= 1'b0;
      qwait();
   endtask : i2c_stop

   task automatic bit9(input logic b, output logic r);
      sda_pull <= !b;
      qwait();
      sclk <= 1'b1;
      qwait();
      r = sda;
      qwait();
      sclk <= 1'b0;
      qwait();
   endtask : bit9

   // result is read byte, or device acknowledge (0 = ack) for writes
   task automatic xfer(input logic [7:0] d, input logic rd, input logic mack);
      logic [7:0] r;
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit9(d[i], r[i]);
      end
      bit9(mack, a);
      res = rd ? r : {7'h00, a};
      -> got;
   endtask : xfer

endmodule : avsc_host

`default_nettype wire

// ==== avsc_pkg.sv ====
// avsc_pkg: constants and carrier types of the av switch control port.
// assumes: included before avsc_port, the checker and the bench top, which all use it.
`default_nettype none

package avsc_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [4:0] ADDR_POWER = 5'h00;
   localparam logic [4:0] ADDR_SEL1 = 5'h01;
   localparam logic [4:0] ADDR_SEL2 = 5'h02;
   localparam logic [4:0] ADDR_SEL3 = 5'h03;
   localparam logic [4:0] ADDR_VIDEO_SYNC_DETECTED_SRC = 5'h04;
   localparam logic [4:0] ADDR_ADET_CFG = 5'h05;
   localparam logic [4:0] ADDR_DET_CTL = 5'h06;
   localparam logic [4:0] ADDR_GEN_OUT = 5'h07;
   localparam logic [4:0] ADDR_STATUS = 5'h08;
   localparam logic [4:0] ADDR_LAST_WR = 5'h08;
   localparam logic [4:0] ADDR_LAST_RD = 5'h09;

   // reset values, index 7 down to 0 = registers 07H..00H
   localparam logic [7:0][7:0] REG_DEFAULTS = {
      8'h1F, 8'h02, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int MASK_ADL_BIT = 4;
   localparam int MASK_ADR_BIT = 5;
   localparam int MASK_VS_BIT = 6;
   localparam int VIDEO_DETECT_MODE_BIT = 7;
   localparam int GEN_OUT_W = 5;

   // ---------------------------------------------------------------
   // serial framing
   // ---------------------------------------------------------------
   localparam logic [5:0] SLAVE_ADDR_HI = 6'h08;
   localparam logic [1:0] WIRE4_CHIP_ADDR = 2'h0;
   localparam logic [4:0] WIRE4_HDR_LAST = 5'h07;
   localparam logic [4:0] WIRE4_FRAME_LAST = 5'h0F;
   localparam logic [4:0] WIRE4_FRAME_LEN = 5'h10;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int WIRE4_MAX_KHZ = 5000;
   localparam int I2C_MAX_KHZ = 400;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      I2C_IDLE, I2C_ADDR, I2C_REG, I2C_WDATA, I2C_ACK, I2C_TX, I2C_TXACK
   } avsc_i2c_e;

   typedef struct packed {
      logic [7:0] power;
      logic [7:0] sel1;
      logic [7:0] sel2;
      logic [7:0] sel3;
      logic [7:0] video_sync_detected_src;
      logic [7:0] adet_cfg;
      logic [7:0] det_ctl;
   } avsc_ctrl_s;

   typedef struct packed {
      avsc_i2c_e st;
      avsc_i2c_e after;
      logic [3:0] cnt;
      logic [7:0] sr;
      logic [4:0] ptr;
      logic sda_oe;
      logic acked;
      logic [7:0][7:0] regs;
      logic video_sync_detected;
      logic int_oe;
      logic a_restart;
      logic v_restart;
      logic [8:0][7:0] shadow;
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [1:0] csn_s;
      logic [1:0] pd_s;
      logic [1:0] mode_s;
      logic [1:0] lsb_s;
      logic [1:0] adl_s;
      logic [1:0] adr_s;
      logic [1:0] vs_s;
      logic [2:0] wr_s;
      logic [2:0] rd_s;
   } avsc_sys_s;

   typedef struct packed {
      logic [4:0] cnt;
      logic [14:0] sr;
      logic rd;
      logic [4:0] raddr;
      logic wr_req;
      logic rd_req;
   } avsc_link_s;

endpackage : avsc_pkg

`default_nettype wire

// ==== avsc_port.sv ====
// avsc_port: host control port of the av switch, i2c slave or 4-wire
// serial port, nine-register map, interrupt and general open-drain pins.
// assumes: CLK at 10 MHz; detect circuits outside; pads resolve the
// open-drain and tri-state pins from the _OE outputs.
`timescale 1ns/1ns
`default_nettype none

module avsc_port (
   // system
   input wire logic CLK,
   input wire logic RESET,
   input wire logic POWERDOWN_N,
   // serial port pins
   input wire logic PORT_MODE_SELECT,
   input wire logic PORT_SELECT_N,
   input wire logic PORT_SERIAL_CLOCK,
   input wire logic PORT_SERIAL_IN,
   output logic PORT_SERIAL_IN_OUT,
   output logic PORT_SERIAL_IN_OE,
   output logic PORT_SERIAL_OUT,
   output logic PORT_SERIAL_OUT_OE,
   input wire logic BUS_ADDR_LSB_PIN,
   // detect circuits
   input wire logic AUDIO_LEFT_DETECTED,
   input wire logic AUDIO_RIGHT_DETECTED,
   input wire logic VIDEO_SYNC_DETECTED,
   output logic AUDIO_DETECT_RESTART,
   output logic VIDEO_DETECT_RESTART,
   // control to the analog sections
   output avsc_pkg::avsc_ctrl_s CTRL,
   // open-drain outputs
   output logic INT_OUT,
   output logic INT_OE,
   output logic [avsc_pkg::GEN_OUT_W-1:0] GENERAL_OUT_BITS,
   output logic [avsc_pkg::GEN_OUT_W-1:0] GENERAL_OUT_BITS_OE
);

   avsc_pkg::avsc_sys_s s_ff;
   avsc_pkg::avsc_sys_s nxt_s;
   avsc_pkg::avsc_link_s l_ff;
   avsc_pkg::avsc_link_s nxt_l;
   // link-domain hold registers and serial output
   logic [4:0] hold_addr_ff;
   logic [7:0] hold_data_ff;
   logic sdo_bit_ff;
   logic sdo_en_ff;

   // ---------------------------------------------------------------
   // read map
   // ---------------------------------------------------------------
   function automatic logic [7:0] rd_byte(input logic [7:0][7:0] regs,
                                          input logic [7:0] status,
                                          input logic [4:0] addr);
      logic [7:0] r;
      // addresses past the status register read as zero
      r = 8'h00;
      if (addr < avsc_pkg::ADDR_STATUS) begin
         r = regs[addr[2:0]];
      end else if (addr == avsc_pkg::ADDR_STATUS) begin
         r = status;
      end
      return r;
   endfunction : rd_byte

   // reads wrap one address later than writes
   function automatic logic [4:0] rd_next(input logic [4:0] p);
      return (p >= avsc_pkg::ADDR_LAST_RD) ? 5'h00 : 5'(p + 5'h01);
   endfunction : rd_next

   function automatic logic [4:0] wr_next(input logic [4:0] p);
      return (p >= avsc_pkg::ADDR_LAST_WR) ? 5'h00 : 5'(p + 5'h01);
   endfunction : wr_next

   // ---------------------------------------------------------------
   // system domain
   // ---------------------------------------------------------------
   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic i2c;
      logic [7:0] status;
      logic [7:0] tx;
      logic wr_en;
      logic [4:0] wr_addr;
      logic [7:0] wr_data;
      logic rd_clr;
      logic load;
      logic irq;

      scl_rise = s_ff.scl_s[1] & ~s_ff.scl_s[2];
      scl_fall = ~s_ff.scl_s[1] & s_ff.scl_s[2];
      start = s_ff.scl_s[1] & s_ff.scl_s[2] & ~s_ff.sda_s[1] & s_ff.sda_s[2];
      stop = s_ff.scl_s[1] & s_ff.scl_s[2] & s_ff.sda_s[1] & ~s_ff.sda_s[2];
      i2c = ~s_ff.mode_s[1];
      status = {1'b0, s_ff.video_sync_detected, s_ff.adr_s[1], s_ff.adl_s[1], 4'h0};
      tx = rd_byte(s_ff.regs, status, s_ff.ptr);
      wr_en = 1'b0;
      wr_addr = s_ff.ptr;
      wr_data = s_ff.sr;
      rd_clr = 1'b0;
      load = 1'b0;
      nxt_s = s_ff;
      nxt_s.scl_s = {s_ff.scl_s[1:0], PORT_SERIAL_CLOCK};
      nxt_s.sda_s = {s_ff.sda_s[1:0], PORT_SERIAL_IN};
      nxt_s.csn_s = {s_ff.csn_s[0], PORT_SELECT_N};
      nxt_s.pd_s = {s_ff.pd_s[0], POWERDOWN_N};
      nxt_s.mode_s = {s_ff.mode_s[0], PORT_MODE_SELECT};
      nxt_s.lsb_s = {s_ff.lsb_s[0], BUS_ADDR_LSB_PIN};
      nxt_s.adl_s = {s_ff.adl_s[0], AUDIO_LEFT_DETECTED};
      nxt_s.adr_s = {s_ff.adr_s[0], AUDIO_RIGHT_DETECTED};
      nxt_s.vs_s = {s_ff.vs_s[0], VIDEO_SYNC_DETECTED};
      nxt_s.wr_s = {s_ff.wr_s[1:0], l_ff.wr_req};
      nxt_s.rd_s = {s_ff.rd_s[1:0], l_ff.rd_req};

      nxt_s.a_restart = 1'b0;
      nxt_s.v_restart = 1'b0;

      // i2c slave
      // pin edges arrive two to three CLK late, well
      // inside a quarter of the fastest bus bit
      if (!i2c || stop) begin
         nxt_s.st = avsc_pkg::I2C_IDLE;
         nxt_s.sda_oe = 1'b0;
      end else if (start) begin
         // repeated start reopens the address phase
         nxt_s.st = avsc_pkg::I2C_ADDR;
         nxt_s.cnt = 4'h0;
         nxt_s.sda_oe = 1'b0;
      end else begin
         case (s_ff.st)
            avsc_pkg::I2C_ADDR, avsc_pkg::I2C_REG, avsc_pkg::I2C_WDATA: begin
               if (scl_rise) begin
                  nxt_s.sr = {s_ff.sr[6:0], s_ff.sda_s[1]};
                  nxt_s.cnt = 4'(s_ff.cnt + 4'h1);
               end else if (scl_fall && s_ff.cnt == avsc_pkg::BYTE_BITS) begin
                  nxt_s.cnt = 4'h0;
                  nxt_s.sda_oe = 1'b1;
                  nxt_s.st = avsc_pkg::I2C_ACK;
                  case (s_ff.st)
                     avsc_pkg::I2C_ADDR: begin
                        if (s_ff.sr[7:1] != {avsc_pkg::SLAVE_ADDR_HI, s_ff.lsb_s[1]}) begin
                           nxt_s.sda_oe = 1'b0;
                           nxt_s.st = avsc_pkg::I2C_IDLE;
                        end
                        nxt_s.after = s_ff.sr[0] ? avsc_pkg::I2C_TX
                                                 : avsc_pkg::I2C_REG;
                     end
                     avsc_pkg::I2C_REG: begin
                        nxt_s.ptr = s_ff.sr[4:0];
                        nxt_s.after = avsc_pkg::I2C_WDATA;
                     end
                     default: begin
                        wr_en = 1'b1;
                        nxt_s.ptr = wr_next(s_ff.ptr);
                        nxt_s.after = avsc_pkg::I2C_WDATA;
                     end
                  endcase
               end
            end
            avsc_pkg::I2C_ACK: begin
               if (scl_fall) begin
                  nxt_s.sda_oe = 1'b0;
                  nxt_s.st = s_ff.after;
                  // a read loads its first byte here
                  load = (s_ff.after == avsc_pkg::I2C_TX);
               end
            end
            avsc_pkg::I2C_TX: begin
               if (scl_fall) begin
                  if (s_ff.cnt == avsc_pkg::BYTE_BITS) begin
                     nxt_s.sda_oe = 1'b0;
                     nxt_s.st = avsc_pkg::I2C_TXACK;
                  end else begin
                     nxt_s.sda_oe = ~s_ff.sr[7];
                     nxt_s.sr = {s_ff.sr[6:0], 1'b0};
                     nxt_s.cnt = 4'(s_ff.cnt + 4'h1);
                  end
               end
            end
            avsc_pkg::I2C_TXACK: begin
               if (scl_rise) begin
                  // low on the ninth bit means go on
                  nxt_s.acked = ~s_ff.sda_s[1];
               end else if (scl_fall) begin
                  load = s_ff.acked;
                  nxt_s.st = s_ff.acked ? avsc_pkg::I2C_TX : avsc_pkg::I2C_IDLE;
               end
            end
            default: begin
               nxt_s.st = avsc_pkg::I2C_IDLE;
               nxt_s.sda_oe = 1'b0;
            end
         endcase
      end

      // first data bit goes out on the same falling edge as the load
      if (load) begin
         nxt_s.sda_oe = ~tx[7];
         nxt_s.sr = {tx[6:0], 1'b0};
         nxt_s.cnt = 4'h1;
         nxt_s.ptr = rd_next(s_ff.ptr);
         // sending the status byte is the clearing read
         rd_clr = (s_ff.ptr == avsc_pkg::ADDR_STATUS);
      end

      // 4-wire requests, hold registers are stable when the flag rises
      if (s_ff.wr_s[1] && !s_ff.wr_s[2]) begin
         wr_en = 1'b1;
         wr_addr = hold_addr_ff;
         wr_data = hold_data_ff;
      end
      // only status reads raise a read request
      if (s_ff.rd_s[1] && !s_ff.rd_s[2]) begin
         rd_clr = 1'b1;
      end

      // status and unused addresses absorb the byte
      if (wr_en && wr_addr < avsc_pkg::ADDR_STATUS) begin
         nxt_s.regs[wr_addr[2:0]] = wr_data;
         nxt_s.v_restart = (wr_addr == avsc_pkg::ADDR_VIDEO_SYNC_DETECTED_SRC);
         nxt_s.a_restart = (wr_addr == avsc_pkg::ADDR_ADET_CFG);
      end

      // video flag: latched in mode 0, live in mode 1; set beats clear
      if (s_ff.regs[avsc_pkg::ADDR_DET_CTL[2:0]][avsc_pkg::VIDEO_DETECT_MODE_BIT]) begin
         nxt_s.video_sync_detected = s_ff.vs_s[1];
      end else begin
         nxt_s.video_sync_detected = s_ff.vs_s[1] | (s_ff.video_sync_detected & ~rd_clr & ~nxt_s.v_restart);
      end

      // power down overrides a write in the same cycle
      if (!s_ff.pd_s[1]) begin
         nxt_s.regs = avsc_pkg::REG_DEFAULTS;
         nxt_s.video_sync_detected = 1'b0;
         nxt_s.ptr = 5'h00;
      end

      // masked flags still read back in status
      irq = (s_ff.adl_s[1] & ~s_ff.regs[avsc_pkg::ADDR_DET_CTL[2:0]][avsc_pkg::MASK_ADL_BIT])
          | (s_ff.adr_s[1] & ~s_ff.regs[avsc_pkg::ADDR_DET_CTL[2:0]][avsc_pkg::MASK_ADR_BIT])
          | (s_ff.video_sync_detected & ~s_ff.regs[avsc_pkg::ADDR_DET_CTL[2:0]][avsc_pkg::MASK_VS_BIT]);
      nxt_s.int_oe = irq;

      // shadow only moves while the 4-wire port is deselected
      // so the link side reads it with no handshake
      if (s_ff.csn_s[1]) begin
         nxt_s.shadow = {status, s_ff.regs};
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         s_ff <= '0;
         // registers start at their defaults, not at zero
         s_ff.regs <= avsc_pkg::REG_DEFAULTS;
         s_ff.st <= avsc_pkg::I2C_IDLE;
         s_ff.after <= avsc_pkg::I2C_IDLE;
         s_ff.shadow <= {8'h00, avsc_pkg::REG_DEFAULTS};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ---------------------------------------------------------------
   // 4-wire link domain, cleared by the frame's own select
   // ---------------------------------------------------------------
   always_comb begin
      logic [15:0] frame;
      logic [7:0] hdr;

      frame = {l_ff.sr, PORT_SERIAL_IN};
      hdr = frame[7:0];
      nxt_l = l_ff;
      nxt_l.sr = frame[14:0];
      // count saturates, extra clocks are ignored
      if (l_ff.cnt != avsc_pkg::WIRE4_FRAME_LEN) begin
         nxt_l.cnt = 5'(l_ff.cnt + 5'h01);
      end
      // header is complete on the eighth rise
      if (l_ff.cnt == avsc_pkg::WIRE4_HDR_LAST && hdr[7:6] == avsc_pkg::WIRE4_CHIP_ADDR
          && hdr[5]) begin
         nxt_l.rd = 1'b1;
         nxt_l.raddr = hdr[4:0];
         nxt_l.rd_req = (hdr[4:0] == avsc_pkg::ADDR_STATUS);
      end
      // data is complete on the sixteenth rise
      if (l_ff.cnt == avsc_pkg::WIRE4_FRAME_LAST && frame[15:14] == avsc_pkg::WIRE4_CHIP_ADDR
          && !frame[13]) begin
         nxt_l.wr_req = 1'b1;
      end
   end

   // select high clears a cut frame at once
   always_ff @(posedge PORT_SERIAL_CLOCK or posedge PORT_SELECT_N) begin
      if (PORT_SELECT_N) begin
         l_ff <= '0;
      end else begin
         l_ff <= nxt_l;
      end
   end

   // write hold registers, read by the system side only after wr_req syncs
   always_ff @(posedge PORT_SERIAL_CLOCK) begin
      if (l_ff.cnt == avsc_pkg::WIRE4_FRAME_LAST) begin
         hold_addr_ff <= l_ff.sr[11:7];
         hold_data_ff <= {l_ff.sr[6:0], PORT_SERIAL_IN};
      end
   end

   // each bit leaves half a clock before the host samples it
   always_ff @(negedge PORT_SERIAL_CLOCK or posedge PORT_SELECT_N) begin
      if (PORT_SELECT_N) begin
         sdo_en_ff <= 1'b0;
         sdo_bit_ff <= 1'b0;
      end else if (l_ff.rd && l_ff.cnt >= 5'h08 && l_ff.cnt < avsc_pkg::WIRE4_FRAME_LEN) begin
         sdo_en_ff <= 1'b1;
         sdo_bit_ff <= (l_ff.raddr > avsc_pkg::ADDR_STATUS) ? 1'b0
                       : s_ff.shadow[l_ff.raddr[3:0]][3'(5'h0F - l_ff.cnt)];
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // open-drain pins only pull low; pads follow the _OE outputs
   assign PORT_SERIAL_IN_OUT = 1'b0;
   assign PORT_SERIAL_IN_OE = s_ff.sda_oe;
   assign PORT_SERIAL_OUT = sdo_bit_ff;
   assign PORT_SERIAL_OUT_OE = sdo_en_ff & ~PORT_SELECT_N & s_ff.mode_s[1];
   assign AUDIO_DETECT_RESTART = s_ff.a_restart;
   assign VIDEO_DETECT_RESTART = s_ff.v_restart;
   assign CTRL = {s_ff.regs[0], s_ff.regs[1], s_ff.regs[2], s_ff.regs[3],
                  s_ff.regs[4], s_ff.regs[5], s_ff.regs[6]};
   assign INT_OUT = 1'b0;
   assign INT_OE = s_ff.int_oe;

   genvar gi;
   for (gi = 0; gi < avsc_pkg::GEN_OUT_W; gi++) begin : g_gen_out
      assign GENERAL_OUT_BITS[gi] = 1'b0;
      assign GENERAL_OUT_BITS_OE[gi] = ~s_ff.regs[avsc_pkg::ADDR_GEN_OUT[2:0]][gi];
   end

endmodule : avsc_port

`default_nettype wire

// ==== avsc_port_properties.sv ====
// avsc_port_properties: pin-level checks of the av switch control port.
// assumes: bound to avsc_port by the bench top; all checks on CLK.
`timescale 1ns/1ns
`default_nettype none

module avsc_port_properties (
   // system
   input wire logic CLK,
   input wire logic RESET,
   input wire logic POWERDOWN_N,
   // serial port
   input wire logic PORT_MODE_SELECT,
   input wire logic PORT_SELECT_N,
   input wire logic PORT_SERIAL_CLOCK,
   input wire logic PORT_SERIAL_IN_OUT,
   input wire logic PORT_SERIAL_IN_OE,
   input wire logic PORT_SERIAL_OUT_OE,
   // detect, control and open-drain pins
   input wire logic AUDIO_LEFT_DETECTED,
   input wire avsc_pkg::avsc_ctrl_s CTRL,
   input wire logic INT_OUT,
   input wire logic INT_OE,
   input wire logic [avsc_pkg::GEN_OUT_W-1:0] GENERAL_OUT_BITS,
   input wire logic [avsc_pkg::GEN_OUT_W-1:0] GENERAL_OUT_BITS_OE
);
   localparam logic [55:0] CTRL_RESET = 56'h01000000004002;
   logic [4:0] rise_n_ff;

   // --------------------------------------------
   // link side helper
   // --------------------------------------------
   // counts rises of a frame; select high ends the frame at once
   always_ff @(posedge PORT_SERIAL_CLOCK or posedge PORT_SELECT_N) begin
      if (PORT_SELECT_N) begin
         rise_n_ff <= 5'h00;
      end else if (rise_n_ff != 5'h1F) begin
         rise_n_ff <= rise_n_ff + 5'h01;
      end
   end

   // --------------------------------------------
   // properties
   // --------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   sequence adl_held_s;
      (AUDIO_LEFT_DETECTED && !CTRL.det_ctl[avsc_pkg::MASK_ADL_BIT])[*5];
   endsequence
   sequence pd_held_s;
      (!POWERDOWN_N)[*4];
   endsequence

   reset_values_a: assert property ($fell(RESET) |-> CTRL == CTRL_RESET && !INT_OE
      && !PORT_SERIAL_IN_OE && GENERAL_OUT_BITS_OE == 5'h00)
      else $error("outputs not at defaults after reset");
   int_source_a: assert property (adl_held_s |-> INT_OE)
      else $error("interrupt not raised by unmasked detect");
   int_masked_a: assert property ((CTRL.det_ctl[6:4] == 3'b111)[*2] |-> !INT_OE)
      else $error("interrupt driven with all masks set");
   open_drain_a: assert property (GENERAL_OUT_BITS == 5'h00 && !INT_OUT
      && !PORT_SERIAL_IN_OUT) else $error("open-drain pin driven high");
   pd_defaults_a: assert property (pd_held_s |=> CTRL == CTRL_RESET
      && GENERAL_OUT_BITS_OE == 5'h00) else $error("power down kept register values");
   out_release_a: assert property (PORT_SELECT_N || !PORT_MODE_SELECT
      |-> !PORT_SERIAL_OUT_OE) else $error("serial out driven while not selected");
   commit_edge_a: assert property (PORT_MODE_SELECT && $changed(CTRL)
      |-> rise_n_ff == 5'h10) else $error("4-wire write landed off the 16th rise");
   sda_steady_a: assert property ($changed(PORT_SERIAL_IN_OE)
      |-> !PORT_SERIAL_CLOCK) else $error("data line moved while clock high");

endmodule : avsc_port_properties

`default_nettype wire
